/* rsc_pkg.sv */
// Purpose: Shared constants and types for reset and strap capture
// Assumes: 10 MHz mclk, strap pins held stable around power-good rise
// Notes:   Register word layouts follow the packed structs below
package rsc_pkg;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int         ADDR_W = 2;
  localparam int         DATA_W = 16;
  localparam logic [1:0] REG_CFG   = 2'h0;
  localparam logic [1:0] REG_SMB   = 2'h1;
  localparam logic [1:0] REG_CTRL  = 2'h2;
  localparam logic [1:0] REG_STRAP = 2'h3;
  localparam int         CTRL_BUS_RST_BIT = 0;
  localparam logic       CTRL_RST = 1'b0;

  // ----------------------------------------------------------------
  // Strap encodings
  // ----------------------------------------------------------------
  localparam logic       TEST_A_NORMAL = 1'b1;
  localparam logic       TEST_B_NORMAL = 1'b0;
  localparam int         SLOT_HP_BIT   = 3;
  localparam logic [3:0] SLOT_RSVD     = 4'h8;
  localparam logic [3:0] SLOT_PAR1     = 4'h9;
  localparam logic [3:0] SLOT_PAR2     = 4'ha;
  localparam logic [3:0] SLOT_SER_LO   = 4'hb;
  localparam logic [3:0] SLOT_SER_HI   = 4'he;
  localparam logic [3:0] SLOT_NOGLUE   = 4'hf;
  localparam logic [3:0] SERIAL_BASE   = 4'h8;
  localparam logic [3:0] CNT_NONE      = 4'h0;
  localparam logic [3:0] CNT_ONE       = 4'h1;
  localparam logic [3:0] CNT_TWO       = 4'h2;
  localparam logic [1:0] SMB_TOP_FIXED = 2'h3;
  localparam logic       SMB_BIT4      = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] smbus_addr_strap;     // Address bits 5,3,2,1
    logic       conv_pci_66_select;
    logic       pcix_capable_mode;
    logic       pcix_max_freq_select;
    logic [3:0] hotplug_slot_config;
    logic       test_strap_b;
    logic       test_strap_a;
  } rsc_strap_type;

  typedef struct packed {
    logic [3:0] slot_count;
    logic       slot_rsvd;
    logic       hp_no_glue;
    logic       hp_serial;
    logic       hp_parallel;
    logic       hp_en;
    logic       pci_66;
    logic       pcix_133;
    logic       pcix_mode;
    logic       test_rsvd_b;
    logic       test_rsvd_a;
    logic       valid;
  } rsc_cfg_type;

  localparam rsc_strap_type STRAP_RST = '0;
  localparam rsc_cfg_type   CFG_RST   = '0;
  localparam logic [6:0]    SMB_RST   = 7'h00;

endpackage : rsc_pkg

/* rsc_rst_sync.sv */
// Purpose: Reset synchroniser, asserts at once and releases on mclk
// Assumes: in_n may change at any time
// Notes:   Output comes from the second flip-flop
`timescale 1ns/10ps
module rsc_rst_sync (
  input  wire logic mclk,
  input  wire logic in_n,
  output logic      out_n
);

  logic stage1;

  // ----------------------------------------------------------------
  // Two-stage release
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge in_n) begin
    if (!in_n) begin
      stage1 <= 1'b0;
      out_n  <= 1'b0;
    end else begin
      stage1 <= 1'b1;
      out_n  <= stage1;
    end
  end

endmodule : rsc_rst_sync

/* rsc_reset_strap_capture.sv */
// Purpose: Reset handling and configuration strap capture with decode
// Assumes: Strap pins settle before power_good rises
// Notes:   Captured straps survive reset_input_n, cleared only by low power_good or arst_n
`timescale 1ns/10ps
// Functional notes
// - Low power_good resets the device asynchronously; high means supplies stable.
// - Straps captured at power_good rise; pins then free for normal use.
// - reset_input_n asserted resets logic and asserts the PCI bus reset.
// - test_strap_a normally 1; captured 0 flagged as reserved test setting.
// - test_strap_b normally 0; captured 1 flagged as reserved test setting.
// - Slot config bit 3 enables hot plug; 0 disables it.
// - Codes 0000-0111: hot plug off, slot count is value plus one.
// - 1001 parallel one slot, 1010 parallel two, 1111 one slot no glue.
// - 1011-1110 serial hot plug three to six slots; 1000 reserved.
// - PCI-X frequency strap used only in PCI-X mode and hot plug off/no-glue.
// - Applied frequency strap 1 gives 133 MHz, 0 limits to 100 MHz.
// - Conventional mode, hot plug off/no-glue: 66 MHz strap 1 gives 66 MHz, else 33 MHz.
// - SMBus address is 1,1,strap5,0,strap3,strap2,strap1.
module rsc_reset_strap_capture (
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  input  wire logic                  power_good,
  input  wire logic                  reset_input_n,
  input  wire rsc_pkg::rsc_strap_type strap_pins,
  input  wire logic [rsc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [rsc_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [rsc_pkg::DATA_W-1:0] reg_rdata,
  output rsc_pkg::rsc_cfg_type       cfg,
  output logic [6:0]                 smbus_addr,
  output logic                       pci_bus_reset_out_n
);

  // ----------------------------------------------------------------
  // Reset generation
  // ----------------------------------------------------------------
  logic por_rst_n;
  logic logic_rst_n;
  wire  por_in_n   = arst_n & power_good;
  wire  logic_in_n = arst_n & power_good & reset_input_n;

  rsc_rst_sync u_por_sync (
    .mclk  (mclk),
    .in_n  (por_in_n),
    .out_n (por_rst_n)
  );

  rsc_rst_sync u_logic_sync (
    .mclk  (mclk),
    .in_n  (logic_in_n),
    .out_n (logic_rst_n)
  );

  // ----------------------------------------------------------------
  // Strap pin synchroniser
  // ----------------------------------------------------------------
  rsc_pkg::rsc_strap_type strap_s1;
  rsc_pkg::rsc_strap_type strap_s2;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      strap_s1 <= rsc_pkg::STRAP_RST;
      strap_s2 <= rsc_pkg::STRAP_RST;
    end else begin
      strap_s1 <= strap_pins;
      strap_s2 <= strap_s1;
    end
  end

  // ----------------------------------------------------------------
  // Capture once per power_good rise
  // ----------------------------------------------------------------
  logic                   captured;
  rsc_pkg::rsc_strap_type raw_q;
  wire                    do_capture = !captured;

  always_ff @(posedge mclk or negedge por_rst_n) begin
    if (!por_rst_n) begin
      captured <= 1'b0;
      raw_q    <= rsc_pkg::STRAP_RST;
    end else begin
      captured <= 1'b1;
      if (do_capture) begin
        raw_q <= strap_s2;
      end
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire [3:0] slot      = raw_q.hotplug_slot_config;
  wire       hp_en     = slot[rsc_pkg::SLOT_HP_BIT];
  wire       no_glue   = (slot == rsc_pkg::SLOT_NOGLUE);
  wire       par_two   = (slot == rsc_pkg::SLOT_PAR2);
  wire       parallel  = (slot == rsc_pkg::SLOT_PAR1) || par_two || no_glue;
  wire       serial    = (slot >= rsc_pkg::SLOT_SER_LO) &&
                         (slot <= rsc_pkg::SLOT_SER_HI);
  wire       slot_rsvd = (slot == rsc_pkg::SLOT_RSVD);
  wire       freq_ok   = !hp_en || no_glue;
  wire [3:0] cnt_off   = 4'(slot + rsc_pkg::CNT_ONE);
  wire [3:0] cnt_ser   = 4'(slot - rsc_pkg::SERIAL_BASE);
  wire [3:0] cnt_par   = par_two ? rsc_pkg::CNT_TWO : rsc_pkg::CNT_ONE;
  wire [3:0] cnt_on    = serial ? cnt_ser :
                         (slot_rsvd ? rsc_pkg::CNT_NONE : cnt_par);
  wire [6:0] next_smb  = {rsc_pkg::SMB_TOP_FIXED, raw_q.smbus_addr_strap[3],
                          rsc_pkg::SMB_BIT4, raw_q.smbus_addr_strap[2:0]};

  rsc_pkg::rsc_cfg_type next_cfg;

  always_comb begin
    next_cfg             = rsc_pkg::CFG_RST;
    next_cfg.valid       = captured;
    next_cfg.test_rsvd_a = raw_q.test_strap_a != rsc_pkg::TEST_A_NORMAL;
    next_cfg.test_rsvd_b = raw_q.test_strap_b != rsc_pkg::TEST_B_NORMAL;
    next_cfg.pcix_mode   = raw_q.pcix_capable_mode;
    next_cfg.pcix_133    = freq_ok && raw_q.pcix_capable_mode &&
                           raw_q.pcix_max_freq_select;
    next_cfg.pci_66      = freq_ok && !raw_q.pcix_capable_mode &&
                           raw_q.conv_pci_66_select;
    next_cfg.hp_en       = hp_en;
    next_cfg.hp_parallel = parallel;
    next_cfg.hp_serial   = serial;
    next_cfg.hp_no_glue  = no_glue;
    next_cfg.slot_rsvd   = slot_rsvd;
    next_cfg.slot_count  = hp_en ? cnt_on : cnt_off;
  end

  always_ff @(posedge mclk or negedge por_rst_n) begin
    if (!por_rst_n) begin
      cfg        <= rsc_pkg::CFG_RST;
      smbus_addr <= rsc_pkg::SMB_RST;
    end else begin
      cfg        <= next_cfg;
      smbus_addr <= next_smb;
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  logic bus_rst_ctrl;
  wire  sel_ctrl  = (reg_addr == rsc_pkg::REG_CTRL);
  wire  wr_ctrl   = reg_wr && sel_ctrl;
  wire [rsc_pkg::DATA_W-1:0] rd_cfg   = rsc_pkg::DATA_W'(cfg);
  wire [rsc_pkg::DATA_W-1:0] rd_smb   = rsc_pkg::DATA_W'(smbus_addr);
  wire [rsc_pkg::DATA_W-1:0] rd_ctrl  = rsc_pkg::DATA_W'(bus_rst_ctrl);
  wire [rsc_pkg::DATA_W-1:0] rd_strap = rsc_pkg::DATA_W'(raw_q);
  wire [rsc_pkg::DATA_W-1:0] rd_mux   =
    (reg_addr == rsc_pkg::REG_CFG) ? rd_cfg :
    (reg_addr == rsc_pkg::REG_SMB) ? rd_smb :
    sel_ctrl                       ? rd_ctrl : rd_strap;
  wire [rsc_pkg::DATA_W-1:0] next_rdata = reg_rd ? rd_mux : '0;

  always_ff @(posedge mclk or negedge logic_rst_n) begin
    if (!logic_rst_n) begin
      bus_rst_ctrl <= rsc_pkg::CTRL_RST;
      reg_rdata    <= '0;
    end else begin
      reg_rdata <= next_rdata;
      if (wr_ctrl) begin
        bus_rst_ctrl <= reg_wdata[rsc_pkg::CTRL_BUS_RST_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // PCI bus reset output
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge logic_rst_n) begin
    if (!logic_rst_n) begin
      pci_bus_reset_out_n <= 1'b0;
    end else begin
      pci_bus_reset_out_n <= !bus_rst_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!por_rst_n);

  property p_pg_low_clears;
    disable iff (!arst_n) !power_good |-> ##1 (!cfg.valid && !captured);
  endproperty
  a_pg_low_clears: assert property (p_pg_low_clears)
    else $error("Configuration survived low power_good");

  property p_capture;
    (por_rst_n && !captured) |=> (raw_q == $past(strap_s2)) ##1 cfg.valid;
  endproperty
  a_capture: assert property (p_capture)
    else $error("Straps not captured after power_good rise");

  property p_bus_reset;
    !reset_input_n |=> !pci_bus_reset_out_n [*3];
  endproperty
  a_bus_reset: assert property (p_bus_reset)
    else $error("PCI bus reset not held during reset input");

  property p_test_a;
    captured |=> cfg.test_rsvd_a == !$past(raw_q.test_strap_a);
  endproperty
  a_test_a: assert property (p_test_a)
    else $error("Test strap A decode wrong");

  property p_test_b;
    captured |=> cfg.test_rsvd_b == $past(raw_q.test_strap_b);
  endproperty
  a_test_b: assert property (p_test_b)
    else $error("Test strap B decode wrong");

  property p_hp_en;
    captured |=> cfg.hp_en == $past(raw_q.hotplug_slot_config[3]);
  endproperty
  a_hp_en: assert property (p_hp_en)
    else $error("Hot plug enable decode wrong");

  property p_cnt_off;
    (captured && !raw_q.hotplug_slot_config[3]) |=>
      cfg.slot_count == 4'($past(raw_q.hotplug_slot_config) + 4'h1);
  endproperty
  a_cnt_off: assert property (p_cnt_off)
    else $error("Slot count wrong with hot plug off");

  property p_par;
    (captured && raw_q.hotplug_slot_config == 4'ha) |=>
      cfg.hp_parallel && cfg.slot_count == 4'h2 && !cfg.hp_no_glue;
  endproperty
  a_par: assert property (p_par)
    else $error("Two-slot parallel decode wrong");

  property p_ser;
    (captured && raw_q.hotplug_slot_config == 4'hd) |=>
      cfg.hp_serial && !cfg.hp_parallel && cfg.slot_count == 4'h5;
  endproperty
  a_ser: assert property (p_ser)
    else $error("Serial hot plug decode wrong");

  property p_freq_gate;
    (captured && raw_q.hotplug_slot_config == 4'h9) |=> !cfg.pcix_133 && !cfg.pci_66;
  endproperty
  a_freq_gate: assert property (p_freq_gate)
    else $error("Frequency strap applied in parallel mode");

  property p_133;
    (captured && raw_q.hotplug_slot_config == 4'hf && raw_q.pcix_capable_mode) |=>
      cfg.pcix_133 == $past(raw_q.pcix_max_freq_select);
  endproperty
  a_133: assert property (p_133)
    else $error("PCI-X 133 MHz decode wrong");

  property p_66;
    (captured && !raw_q.hotplug_slot_config[3] && !raw_q.pcix_capable_mode) |=>
      cfg.pci_66 == $past(raw_q.conv_pci_66_select) && !cfg.pcix_133;
  endproperty
  a_66: assert property (p_66)
    else $error("Conventional 66 MHz decode wrong");

  property p_smb;
    captured |=> smbus_addr[6:5] == 2'h3 && !smbus_addr[3] &&
      smbus_addr[4] == $past(raw_q.smbus_addr_strap[3]) &&
      smbus_addr[2:0] == $past(raw_q.smbus_addr_strap[2:0]);
  endproperty
  a_smb: assert property (p_smb)
    else $error("SMBus address wrong");

  property p_hold;
    (captured && power_good) |=> $stable(raw_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Captured straps changed");

  property p_pci_follow;
    disable iff (!logic_rst_n) (logic_rst_n && !bus_rst_ctrl) |=> pci_bus_reset_out_n;
  endproperty
  a_pci_follow: assert property (p_pci_follow)
    else $error("PCI bus reset held without cause");

  property p_slot_rsvd;
    (captured && raw_q.hotplug_slot_config == 4'h8) |=>
      cfg.slot_rsvd && !cfg.hp_parallel && !cfg.hp_serial;
  endproperty
  a_slot_rsvd: assert property (p_slot_rsvd)
    else $error("Reserved slot code decode wrong");

  property p_noglue;
    (captured && raw_q.hotplug_slot_config == 4'hf) |=>
      cfg.hp_parallel && cfg.hp_no_glue && cfg.slot_count == 4'h1;
  endproperty
  a_noglue: assert property (p_noglue)
    else $error("No-glue parallel decode wrong");

  c_capture:   cover property ((por_rst_n && !captured) ##1 captured);
  c_serial:    cover property (cfg.valid && cfg.hp_serial);
  c_sw_reset:  cover property (wr_ctrl ##1 bus_rst_ctrl ##1 !pci_bus_reset_out_n);
  c_rd_cfg:    cover property (reg_rd && reg_addr == rsc_pkg::REG_CFG ##1 reg_rdata != '0);
  c_noglue:    cover property (cfg.valid && cfg.hp_no_glue);

endmodule : rsc_reset_strap_capture

/* rsc_board_model.sv */
// Purpose: Board straps, supply and platform reset seen by the block
// Assumes: Bench commands supply and reset levels and strap values
// Notes:   Pins toggle once the strap hold window has passed
`timescale 1ns/10ps
module rsc_board_model (
  input  wire logic                   mclk,
  input  wire logic                   pg_on,
  input  wire logic                   rst_on_n,
  input  wire rsc_pkg::rsc_strap_type board_straps,
  output logic                        power_good,
  output logic                        reset_input_n,
  output rsc_pkg::rsc_strap_type      strap_pins
);
  // ----------------------------------------------------------------
  // Supply, reset source and strap resistors
  // ----------------------------------------------------------------
  logic [3:0] hold_cnt;

  assign power_good    = pg_on;
  assign reset_input_n = rst_on_n;

  always_ff @(posedge mclk) begin
    if (!pg_on) begin
      hold_cnt   <= 4'h0;
      strap_pins <= board_straps;
    end else if (hold_cnt != 4'h8) begin
      hold_cnt   <= hold_cnt + 4'h1;
      strap_pins <= board_straps;
    end else begin
      strap_pins <= ~strap_pins;
    end
  end
endmodule : rsc_board_model

/* rsc_reset_strap_capture_bench.sv */
// Purpose: Self-checking bench for reset and strap capture
// Assumes: 10 MHz mclk, board model drives pins
// Notes:   One task per scenario
`timescale 1ns/10ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin failures++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module rsc_reset_strap_capture_bench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                   mclk;
  logic                   arst_n;
  logic                   pg_on;
  logic                   rst_on_n;
  rsc_pkg::rsc_strap_type board_straps;
  logic                   power_good;
  logic                   reset_input_n;
  rsc_pkg::rsc_strap_type strap_pins;
  logic [1:0]             reg_addr;
  logic [15:0]            reg_wdata;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [15:0]            reg_rdata;
  rsc_pkg::rsc_cfg_type   cfg;
  rsc_pkg::rsc_cfg_type   last_cfg;
  logic [6:0]             smbus_addr;
  logic                   pci_bus_reset_out_n;
  int                     failures = 0;
  int                     comparisons = 0;

  rsc_board_model board (.mclk(mclk), .pg_on(pg_on), .rst_on_n(rst_on_n),
    .board_straps(board_straps), .power_good(power_good),
    .reset_input_n(reset_input_n), .strap_pins(strap_pins));

  rsc_reset_strap_capture dut (.mclk(mclk), .arst_n(arst_n), .power_good(power_good),
    .reset_input_n(reset_input_n), .strap_pins(strap_pins), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cfg(cfg), .smbus_addr(smbus_addr), .pci_bus_reset_out_n(pci_bus_reset_out_n));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic rsc_pkg::rsc_cfg_type exp_cfg(input rsc_pkg::rsc_strap_type s);
    rsc_pkg::rsc_cfg_type c;
    logic [3:0]           v;
    logic                 plain;
    v = s.hotplug_slot_config;
    plain = !v[3] || (v == 4'hf);
    c = '0;
    c.valid = 1'b1;
    c.test_rsvd_a = !s.test_strap_a;
    c.test_rsvd_b = s.test_strap_b;
    c.pcix_mode = s.pcix_capable_mode;
    c.pcix_133 = plain && s.pcix_capable_mode && s.pcix_max_freq_select;
    c.pci_66 = plain && !s.pcix_capable_mode && s.conv_pci_66_select;
    c.hp_en = v[3];
    c.hp_parallel = (v == 4'h9) || (v == 4'ha) || (v == 4'hf);
    c.hp_serial = (v >= 4'hb) && (v <= 4'he);
    c.hp_no_glue = (v == 4'hf);
    c.slot_rsvd = (v == 4'h8);
    c.slot_count = !v[3] ? v + 4'h1 : (v == 4'h8) ? 4'h0 : (v == 4'ha) ? 4'h2 :
                   c.hp_serial ? v - 4'h8 : 4'h1;
    return c;
  endfunction : exp_cfg

  task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [1:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask : reg_read

  task automatic stop_test;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic power_up_decode(input logic [3:0] code);
    rsc_pkg::rsc_strap_type s;
    s.hotplug_slot_config = code;
    s.test_strap_a = (code != 4'h5);
    s.test_strap_b = (code == 4'h6);
    s.pcix_capable_mode = code[0];
    s.pcix_max_freq_select = code[1];
    s.conv_pci_66_select = ~code[1];
    s.smbus_addr_strap = code ^ 4'h5;
    last_cfg = exp_cfg(s);
    @(posedge mclk);
    pg_on        <= 1'b0;
    board_straps <= s;
    repeat (3) @(posedge mclk);
    pg_on <= 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    `CHK(cfg, last_cfg)
    `CHK(smbus_addr, {2'h3, s.smbus_addr_strap[3], 1'b0, s.smbus_addr_strap[2:0]})
    repeat (12) @(posedge mclk);
    #1;
    `CHK(cfg, last_cfg)
    reg_read(rsc_pkg::REG_STRAP, {3'h0, s});
    reg_read(rsc_pkg::REG_SMB, {9'h0, 2'h3, s.smbus_addr_strap[3], 1'b0,
             s.smbus_addr_strap[2:0]});
  endtask : power_up_decode

  task automatic reg_access;
    reg_write(rsc_pkg::REG_CFG, 16'hffff);
    reg_write(rsc_pkg::REG_CTRL, 16'h0001);
    reg_read(rsc_pkg::REG_CTRL, 16'h0001);
    `CHK(pci_bus_reset_out_n, 1'b0)
    reg_read(rsc_pkg::REG_CFG, {1'b0, last_cfg});
  endtask : reg_access

  task automatic reset_in_test;
    int n;
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      rst_on_n <= 1'b0;
      #1;
      `CHK(pci_bus_reset_out_n, 1'b0)
      repeat (3) @(posedge mclk);
      #1;
      `CHK(cfg, last_cfg)
      @(posedge mclk);
      rst_on_n <= 1'b1;
      n = 0;
      while (pci_bus_reset_out_n !== 1'b1 && n < 8) begin
        @(posedge mclk);
        #1;
        n++;
      end
      `CHK(pci_bus_reset_out_n, 1'b1)
      reg_read(rsc_pkg::REG_CTRL, 16'h0000);
    end
  endtask : reset_in_test

  task automatic power_loss;
    @(posedge mclk);
    pg_on <= 1'b0;
    #1;
    `CHK(cfg, rsc_pkg::CFG_RST)
    `CHK(smbus_addr, rsc_pkg::SMB_RST)
    `CHK(pci_bus_reset_out_n, 1'b0)
    repeat (5) @(posedge mclk);
    #1;
    `CHK(cfg, rsc_pkg::CFG_RST)
  endtask : power_loss

  // ----------------------------------------------------------------
  // Clock, watchdog and sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    #200000;
    failures++;
    stop_test();
  end

  initial begin
    arst_n       = 1'b0;
    pg_on        = 1'b0;
    rst_on_n     = 1'b0;
    board_straps = 13'h0001;
    reg_addr     = 2'h0;
    reg_wdata    = 16'h0000;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    repeat (10) @(posedge mclk);
    arst_n   <= 1'b1;
    rst_on_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      power_up_decode(i[3:0]);
    end
    reg_access();
    reset_in_test();
    power_loss();
    stop_test();
  end
endmodule : rsc_reset_strap_capture_bench
